/* File: rtl/uhtb_host_token.sv */
// Host token command, SOF threshold and descriptor table base registers.
`timescale 1ns/1ns
`default_nettype none
module uhtb_host_token (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire uhtb_pkg::uhtb_bus_s bus,
  output logic [31:0] readData,
  output uhtb_pkg::uhtb_token_s tokenCmd,
  output logic tokenStart,
  input wire logic tokenDone,
  output logic tokenInProgress,
  output logic [31:0] tableBaseAddr,
  output logic [7:0] sofThresholdCount,
  output logic nextTokenLowSpeed,
  output logic hostMode
);
  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    UHTB_IDLE = 2'b01,
    UHTB_BUSY = 2'b10
  } uhtb_state_e;

  typedef struct packed {
    uhtb_state_e st;
    logic [7:0] tokenReg;
    logic [7:0] sofReg;
    logic [6:0] tableBaseAddrLow;
    logic [7:0] tableBaseAddrHigh;
    logic [7:0] tableBaseAddrUpper;
    logic lowSpd;
    logic host;
    logic start;
    uhtb_pkg::uhtb_token_s cmd;
    logic [31:0] rdata;
  } uhtb_regs_s;

  uhtb_regs_s state_r;
  uhtb_regs_s state_nxt;
  logic [1:0] decodedKind;

  function automatic logic [31:0] zext8(input logic [7:0] v);
    zext8 = {24'h000000, v};
  endfunction : zext8

  uhtb_token_decode tokDec (
    .pidCode(bus.wdata[7:4]),
    .kind(decodedKind)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    state_nxt.start = 1'b0;
    state_nxt.rdata = 32'h00000000;
    case (state_r.st)
      UHTB_IDLE: begin
        state_nxt.st = UHTB_IDLE;
      end
      UHTB_BUSY: begin
        if (tokenDone || !state_r.host) begin
          state_nxt.st = UHTB_IDLE;
        end
      end
      default: state_nxt.st = UHTB_IDLE;
    endcase
    if (bus.wr) begin
      case (bus.addr)
        uhtb_pkg::ADDR_TOKEN: begin
          state_nxt.tokenReg = bus.wdata[7:0];
          // A write while busy is stored but not launched; software must poll first.
          if (state_r.host && state_r.st == UHTB_IDLE &&
              decodedKind != uhtb_pkg::KIND_NONE) begin
            state_nxt.start = 1'b1;
            state_nxt.st = UHTB_BUSY;
            state_nxt.cmd.kind = decodedKind;
            state_nxt.cmd.endpoint = bus.wdata[3:0];
            state_nxt.cmd.lowSpeed = state_r.lowSpd;
          end
        end
        uhtb_pkg::ADDR_SOF: state_nxt.sofReg = bus.wdata[7:0];
        uhtb_pkg::ADDR_BASE_LOW: begin
          state_nxt.tableBaseAddrLow = bus.wdata[7:uhtb_pkg::BASE_LOW_LSB];
        end
        uhtb_pkg::ADDR_BASE_HIGH: state_nxt.tableBaseAddrHigh = bus.wdata[7:0];
        uhtb_pkg::ADDR_BASE_UPPER: state_nxt.tableBaseAddrUpper = bus.wdata[7:0];
        uhtb_pkg::ADDR_CTRL: begin
          state_nxt.host = bus.wdata[uhtb_pkg::CTRL_HOST_BIT];
          state_nxt.lowSpd = bus.wdata[uhtb_pkg::CTRL_LOWSPD_BIT];
        end
        default: ;
      endcase
    end
    if (bus.rd) begin
      case (bus.addr)
        uhtb_pkg::ADDR_TOKEN: state_nxt.rdata = zext8(state_r.tokenReg);
        uhtb_pkg::ADDR_SOF: state_nxt.rdata = zext8(state_r.sofReg);
        uhtb_pkg::ADDR_BASE_LOW: begin
          state_nxt.rdata = zext8({state_r.tableBaseAddrLow, 1'b0});
        end
        uhtb_pkg::ADDR_BASE_HIGH: state_nxt.rdata = zext8(state_r.tableBaseAddrHigh);
        uhtb_pkg::ADDR_BASE_UPPER: state_nxt.rdata = zext8(state_r.tableBaseAddrUpper);
        uhtb_pkg::ADDR_CTRL: state_nxt.rdata = zext8({6'h00, state_r.lowSpd, state_r.host});
        uhtb_pkg::ADDR_STATUS: begin
          state_nxt.rdata = zext8({7'h00, state_r.st == UHTB_BUSY});
        end
        default: state_nxt.rdata = 32'h00000000;
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge sys_clk) begin
    if (!reset_n) begin
      state_r.st <= UHTB_IDLE;
      state_r.tokenReg <= uhtb_pkg::RESET_BYTE;
      state_r.sofReg <= uhtb_pkg::RESET_BYTE;
      state_r.tableBaseAddrLow <= 7'h00;
      state_r.tableBaseAddrHigh <= uhtb_pkg::RESET_BYTE;
      state_r.tableBaseAddrUpper <= uhtb_pkg::RESET_BYTE;
      state_r.lowSpd <= 1'b0;
      state_r.host <= 1'b0;
      state_r.start <= 1'b0;
      state_r.cmd <= '0;
      state_r.rdata <= 32'h00000000;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign readData = state_r.rdata;
  assign tokenCmd = state_r.cmd;
  assign tokenStart = state_r.start;
  assign tokenInProgress = (state_r.st == UHTB_BUSY);
  assign tableBaseAddr = {state_r.tableBaseAddrUpper, state_r.tableBaseAddrHigh,
                          state_r.tableBaseAddrLow, uhtb_pkg::ALIGN_ZERO};
  assign sofThresholdCount = state_r.sofReg;
  assign nextTokenLowSpeed = state_r.lowSpd;
  assign hostMode = state_r.host;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  // Each launch check is split into the request that qualifies and the answer
  // one cycle later, so a failure points at either the decode or the handoff.
  sequence s_launch_setup;
    bus.wr && bus.addr == uhtb_pkg::ADDR_TOKEN && state_r.host && !tokenInProgress &&
      bus.wdata[7:4] == uhtb_pkg::PID_SETUP;
  endsequence

  sequence s_launch_in;
    bus.wr && bus.addr == uhtb_pkg::ADDR_TOKEN && state_r.host && !tokenInProgress &&
      bus.wdata[7:4] == uhtb_pkg::PID_IN;
  endsequence

  sequence s_launch_out;
    bus.wr && bus.addr == uhtb_pkg::ADDR_TOKEN && state_r.host && !tokenInProgress &&
      bus.wdata[7:4] == uhtb_pkg::PID_OUT;
  endsequence

  sequence s_launch_any;
    bus.wr && bus.addr == uhtb_pkg::ADDR_TOKEN && state_r.host && !tokenInProgress &&
      decodedKind != uhtb_pkg::KIND_NONE;
  endsequence

  sequence s_reserved_write;
    bus.wr && bus.addr == uhtb_pkg::ADDR_TOKEN && bus.wdata[7:4] != uhtb_pkg::PID_SETUP &&
      bus.wdata[7:4] != uhtb_pkg::PID_IN && bus.wdata[7:4] != uhtb_pkg::PID_OUT;
  endsequence

  // ----------------------------------------------------------------
  // Token launch
  // ----------------------------------------------------------------
  a_setup_launch: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_launch_setup |=> tokenStart && tokenCmd.kind == uhtb_pkg::KIND_SETUP && tokenInProgress)
    else $error("setup token not launched");

  a_in_decode: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_launch_in |=> tokenStart && tokenCmd.kind == uhtb_pkg::KIND_IN)
    else $error("in token decode wrong");

  a_out_decode: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_launch_out |=> tokenStart && tokenCmd.kind == uhtb_pkg::KIND_OUT)
    else $error("out token decode wrong");

  // Reserved codes are stored for readback but must never reach the link.
  a_reserved_idle: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_reserved_write |=> !tokenStart)
    else $error("reserved token code launched");

  a_cmd_stable: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !tokenStart |-> $stable(tokenCmd))
    else $error("token command changed without launch");

  a_host_launch: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_launch_any |=> tokenStart && tokenInProgress)
    else $error("accepted token not launched");

  a_endpoint_copy: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    s_launch_any |=> tokenCmd.endpoint == $past(bus.wdata[3:0]))
    else $error("token endpoint not copied");

  a_no_start_guest: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !hostMode |=> !tokenStart)
    else $error("token started outside host mode");

  a_start_single: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    tokenStart |=> !tokenStart)
    else $error("token start longer than one cycle");

  // ----------------------------------------------------------------
  // Busy indication
  // ----------------------------------------------------------------
  // A second write while busy would otherwise clobber the command in flight.
  a_busy_refuse: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    bus.wr && bus.addr == uhtb_pkg::ADDR_TOKEN && tokenInProgress |=> !tokenStart)
    else $error("token launched while busy");

  a_busy_holds: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    tokenStart ##1 (!tokenDone && hostMode) |-> tokenInProgress)
    else $error("busy dropped early");

  a_done_clears: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    tokenInProgress && tokenDone |=> !tokenInProgress)
    else $error("busy not cleared by done");

  // ----------------------------------------------------------------
  // Register readback
  // ----------------------------------------------------------------
  a_token_upper_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    bus.rd && bus.addr == uhtb_pkg::ADDR_TOKEN |=> readData[31:8] == 24'h000000)
    else $error("token upper bits not zero");

  a_sof_upper_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    bus.rd && bus.addr == uhtb_pkg::ADDR_SOF |=> readData[31:8] == 24'h000000)
    else $error("threshold upper bits not zero");

  a_sof_readback: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    bus.rd && bus.addr == uhtb_pkg::ADDR_SOF |=> readData[7:0] == sofThresholdCount)
    else $error("threshold readback wrong");

  a_read_idle_zero: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    !bus.rd |=> readData == 32'h00000000)
    else $error("read data not zero outside a read");

  // ----------------------------------------------------------------
  // Table base
  // ----------------------------------------------------------------
  a_base_low_read: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    bus.rd && bus.addr == uhtb_pkg::ADDR_BASE_LOW |=>
    readData == {24'h000000, tableBaseAddr[15:9], 1'b0})
    else $error("base low readback wrong");

  a_base_align: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    tableBaseAddr[8:0] == 9'h000)
    else $error("table base not aligned");

  a_base_low_write: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    bus.wr && bus.addr == uhtb_pkg::ADDR_BASE_LOW |=> tableBaseAddr[15:9] == $past(bus.wdata[7:1]))
    else $error("base low field not stored");

  a_base_high: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    bus.wr && bus.addr == uhtb_pkg::ADDR_BASE_HIGH |=> tableBaseAddr[23:16] == $past(bus.wdata[7:0]))
    else $error("base high byte not stored");

  a_base_upper: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    bus.wr && bus.addr == uhtb_pkg::ADDR_BASE_UPPER |=> tableBaseAddr[31:24] == $past(bus.wdata[7:0]))
    else $error("base upper byte not stored");

  // ----------------------------------------------------------------
  // Speed select
  // ----------------------------------------------------------------
  // Speed is latched with the command, so a later change cannot alter a token in flight.
  a_speed_follow: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    tokenStart |-> tokenCmd.lowSpeed == $past(nextTokenLowSpeed))
    else $error("token speed mismatch");

  a_speed_store: assert property (
    @(posedge sys_clk) disable iff (!reset_n)
    bus.wr && bus.addr == uhtb_pkg::ADDR_CTRL |=>
    nextTokenLowSpeed == $past(bus.wdata[uhtb_pkg::CTRL_LOWSPD_BIT]))
    else $error("speed select not stored");
endmodule : uhtb_host_token
`default_nettype wire

/* File: rtl/uhtb_pkg.sv */
// Package of constants and carrier types for the host token and table base block.
package uhtb_pkg;
  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0] ADDR_TOKEN = 8'h00;
  localparam logic [7:0] ADDR_SOF = 8'h04;
  localparam logic [7:0] ADDR_BASE_LOW = 8'h08;
  localparam logic [7:0] ADDR_BASE_HIGH = 8'h0c;
  localparam logic [7:0] ADDR_BASE_UPPER = 8'h10;
  localparam logic [7:0] ADDR_CTRL = 8'h14;
  localparam logic [7:0] ADDR_STATUS = 8'h18;
  // ----------------------------------------------------------------
  // Fields and codes
  // ----------------------------------------------------------------
  localparam logic [3:0] PID_SETUP = 4'hd;
  localparam logic [3:0] PID_IN = 4'h9;
  localparam logic [3:0] PID_OUT = 4'h1;
  localparam int CTRL_HOST_BIT = 0;
  localparam int CTRL_LOWSPD_BIT = 1;
  localparam int BASE_LOW_LSB = 1;
  localparam logic [8:0] ALIGN_ZERO = 9'h000;
  localparam logic [7:0] RESET_BYTE = 8'h00;
  localparam logic [7:0] SOF_TH_64 = 8'h4a;
  localparam logic [7:0] SOF_TH_32 = 8'h2a;
  localparam logic [7:0] SOF_TH_8 = 8'h12;
  // ----------------------------------------------------------------
  // Token dispatch
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_NONE = 2'h0;
  localparam logic [1:0] KIND_SETUP = 2'h1;
  localparam logic [1:0] KIND_IN = 2'h2;
  localparam logic [1:0] KIND_OUT = 2'h3;

  typedef struct packed {
    logic [7:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } uhtb_bus_s;

  typedef struct packed {
    logic [1:0] kind;
    logic [3:0] endpoint;
    logic lowSpeed;
  } uhtb_token_s;
endpackage : uhtb_pkg

/* File: rtl/uhtb_token_decode.sv */
// Token type decoder for the host token command register.
`timescale 1ns/1ns
`default_nettype none
module uhtb_token_decode (
  input wire logic [3:0] pidCode,
  output logic [1:0] kind
);
  always_comb begin
    case (pidCode)
      uhtb_pkg::PID_SETUP: kind = uhtb_pkg::KIND_SETUP;
      uhtb_pkg::PID_IN: kind = uhtb_pkg::KIND_IN;
      uhtb_pkg::PID_OUT: kind = uhtb_pkg::KIND_OUT;
      default: kind = uhtb_pkg::KIND_NONE;
    endcase
  end
endmodule : uhtb_token_decode
`default_nettype wire

/* File: verif/uhtb_link_model.sv */
// Behavioural link partner that runs each launched token.
`timescale 1ns/1ns
`default_nettype none
module uhtb_link_model (
  input wire logic sys_clk,
  input wire logic reset_n,
  input wire logic tokenStart,
  input wire logic [3:0] holdCycles,
  output logic tokenDone
);
  logic [3:0] countR;
  // Done comes once per token after a bench-chosen delay, never early.
  always_ff @(posedge sys_clk) begin
    tokenDone <= 1'b0;
    if (!reset_n) begin
      countR <= 4'h0;
    end else if (tokenStart) begin
      countR <= holdCycles;
    end else if (countR != 4'h0) begin
      countR <= countR - 4'h1;
      tokenDone <= (countR == 4'h1);
    end
  end
endmodule : uhtb_link_model
`default_nettype wire

/* File: verif/test_usb_host_token_and_bdt_base.sv */
// Self-checking bench for the host token and table base registers.
`timescale 1ns/1ns
`default_nettype none
module test_usb_host_token_and_bdt_base;
  logic sys_clk, reset_n, tokenStart, tokenDone, tokenInProgress, nextTokenLowSpeed, hostMode;
  logic rdLate;
  logic [3:0] hold;
  logic [7:0] sofThresholdCount;
  logic [31:0] readData, tableBaseAddr, r, regv [5];
  uhtb_pkg::uhtb_bus_s bus;
  uhtb_pkg::uhtb_token_s tokenCmd;
  logic [31:0] rdQ [$];
  uhtb_pkg::uhtb_token_s tokQ [$];
  int n_mismatch, tests_run, i;
  logic [7:0] addrs [5] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10};
  logic [3:0] pids [3] = '{uhtb_pkg::PID_SETUP, uhtb_pkg::PID_IN, uhtb_pkg::PID_OUT};
  logic [1:0] kinds [3] = '{uhtb_pkg::KIND_SETUP, uhtb_pkg::KIND_IN, uhtb_pkg::KIND_OUT};
  logic [7:0] sofs [3] = '{uhtb_pkg::SOF_TH_64, uhtb_pkg::SOF_TH_32, uhtb_pkg::SOF_TH_8};
  uhtb_host_token u_dut (.sys_clk(sys_clk), .reset_n(reset_n), .bus(bus), .readData(readData),
    .tokenCmd(tokenCmd), .tokenStart(tokenStart), .tokenDone(tokenDone),
    .tokenInProgress(tokenInProgress), .tableBaseAddr(tableBaseAddr),
    .sofThresholdCount(sofThresholdCount), .nextTokenLowSpeed(nextTokenLowSpeed),
    .hostMode(hostMode));
  uhtb_link_model u_link (.sys_clk(sys_clk), .reset_n(reset_n), .tokenStart(tokenStart),
    .holdCycles(hold), .tokenDone(tokenDone));
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  function automatic logic [31:0] nextRand(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : nextRand
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask : check
  // Each bus task owns exactly one edge, so strobes never get two writes in one step.
  task automatic op(input logic [7:0] a, input logic [31:0] d, input logic w, input logic rd);
    bus <= '{addr: a, wdata: d, wr: w, rd: rd};
    @(posedge sys_clk);
  endtask : op
  task automatic rdx(input logic [7:0] a, input logic [31:0] exp);
    rdQ.push_back(exp);
    op(a, 32'h0, 1'b0, 1'b1);
  endtask : rdx
  task automatic tally_and_finish;
    $display("Comparisons %0d, mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : tally_and_finish
  // ----------------------------------------------------------------
  // Clock, monitor and watchdog
  // ----------------------------------------------------------------
  initial begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) rdLate <= bus.rd;
  always @(negedge sys_clk) begin
    if (rdLate) check(readData, rdQ.pop_front());
    if (tokenStart && tokQ.size() == 0) check(32'h1, 32'h0);
    else if (tokenStart) check({25'h0, tokenCmd}, {25'h0, tokQ.pop_front()});
  end
  initial begin
    repeat (3000) @(posedge sys_clk);
    n_mismatch++;
    tally_and_finish();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset_n = 1'b0;
    bus = '0;
    hold = 4'h3;
    rdLate = 1'b0;
    r = 32'd92789;
    repeat (3) @(posedge sys_clk);
    reset_n <= 1'b1;
    for (i = 0; i < 8; i++) rdx(8'(i * 4), 32'h0);
    $display("test reset values done");
    for (i = 0; i < 5; i++) begin
      r = nextRand(r);
      if (i == 0) r[7:4] = uhtb_pkg::PID_OUT;
      regv[i] = r;
      op(addrs[i], r, 1'b1, 1'b0);
      rdx(addrs[i], {24'h0, r[7:1], i == 2 ? 1'b0 : r[0]});
    end
    check(tableBaseAddr, {regv[4][7:0], regv[3][7:0], regv[2][7:1], 9'h0});
    op(8'h08, 32'h1, 1'b1, 1'b0);
    op(8'h0, 32'h0, 1'b0, 1'b0);
    check(tableBaseAddr[15:0], 16'h0);
    foreach (pids[i]) begin
      op(8'h04, {24'h0, sofs[i]}, 1'b1, 1'b0);
      rdx(8'h04, {24'h0, sofs[i]});
      check(sofThresholdCount, sofs[i]);
    end
    $display("test registers done");
    foreach (pids[i]) begin
      r = nextRand(r);
      hold <= 4'h3 + r[7:5];
      op(uhtb_pkg::ADDR_CTRL, {30'h0, i[0], 1'b1}, 1'b1, 1'b0);
      tokQ.push_back('{kind: kinds[i], endpoint: r[3:0], lowSpeed: i[0]});
      op(uhtb_pkg::ADDR_TOKEN, {24'h0, pids[i], r[3:0]}, 1'b1, 1'b0);
      rdx(uhtb_pkg::ADDR_STATUS, 32'h1);
      op(8'h0, 32'h0, 1'b0, 1'b0);
      repeat (20) if (tokenInProgress === 1'b1) @(posedge sys_clk);
      check(tokenInProgress, 1'b0);
    end
    op(uhtb_pkg::ADDR_CTRL, 32'h0, 1'b1, 1'b0);
    op(uhtb_pkg::ADDR_TOKEN, 32'hffff_ff13, 1'b1, 1'b0);
    rdx(uhtb_pkg::ADDR_TOKEN, 32'h13);
    op(uhtb_pkg::ADDR_TOKEN, 32'h92, 1'b1, 1'b0);
    rdx(uhtb_pkg::ADDR_STATUS, 32'h0);
    op(8'h0, 32'h0, 1'b0, 1'b0);
    repeat (4) @(posedge sys_clk);
    check(tokQ.size(), 32'h0);
    $display("test tokens done");
    tally_and_finish();
  end
endmodule : test_usb_host_token_and_bdt_base
`default_nettype wire
